/* shared/ebh_pkg.sv */
/*
 * Package for the external bus hold and memory map control block.
 * Assumes a 32-bit AXI4-Lite register bus on a single 100 MHz clock.
 */
`default_nettype none
package ebh_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] EBH_CFG2_OFFSET = 12'h000;
    localparam logic [11:0] EBH_WBUF_OFFSET = 12'h004;
    // Field positions in ext_interface_config_2
    localparam int EBH_FILL_LO = 6;
    localparam int EBH_MAP_BIT = 8;
    localparam int EBH_INHIBIT_BIT = 9;
    localparam int EBH_REQ_BIT = 10;
    localparam int EBH_ACK_BIT = 11;
    // Reset values and fill count limit
    localparam logic EBH_INHIBIT_RST = 1'b0;
    localparam logic [1:0] EBH_FILL_RST = 2'h0;
    localparam logic [1:0] EBH_FILL_MAX = 2'h3;
    // Status settling delay of the fill count
    localparam int EBH_FILL_LAG_NS = 20;
    localparam int EBH_CLK_PERIOD_NS = 10;
    localparam int EBH_FILL_LAG_CYC = (EBH_FILL_LAG_NS + EBH_CLK_PERIOD_NS - 1) / EBH_CLK_PERIOD_NS;
    // AXI responses
    localparam logic [1:0] EBH_RESP_OKAY = 2'h0;
    localparam logic [1:0] EBH_RESP_SLVERR = 2'h2;

    // Grant state machine
    typedef enum logic [1:0] {
        EBH_IDLE = 2'b00,
        EBH_GRANTED = 2'b01,
        EBH_RELEASE = 2'b10
    } ebh_state_e;

    // Write buffer side events
    typedef struct packed {
        logic push;
        logic pop;
    } ebh_wbuf_s;
endpackage
`default_nettype wire

/* src/ebh_ctrl.sv */
/*
 * Hold/grant arbitration, boot map select and write-buffer fill count,
 * with an AXI4-Lite slave for the configuration register.
 * Assumes aresetn is the synchronous chip reset, pins are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
module ebh_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic bus_request_n,
    input wire logic map_select_pin,
    output logic bus_grant_n,
    output logic ext_bus_oe_n,
    output logic map_select,
    output logic zone7_enable,
    output logic boot_rom_enable,
    // Internal side
    input wire ebh_pkg::ebh_wbuf_s wbuf_event,
    input wire logic ext_access,
    output logic ext_not_ready
);
    import ebh_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic req_meta, req_sync, pin_meta, pin_sync;
    logic next_req_meta, next_req_sync, next_pin_meta, next_pin_sync;

    // Two flops per pin
    always_comb begin
        next_req_meta = bus_request_n;
        next_req_sync = req_meta;
        next_pin_meta = map_select_pin;
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge aclk) begin
        req_meta <= next_req_meta;
        req_sync <= next_req_sync;
        pin_meta <= next_pin_meta;
        pin_sync <= next_pin_sync;
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held, next_w_held;
    logic [11:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_fire;
    logic map_bit, inhibit;
    logic next_map_bit, next_inhibit;
    logic [1:0] fill_count, fill_shown;
    logic [31:0] cfg_word;

    // Configuration register read value
    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[EBH_FILL_LO +: 2] = fill_shown;
        cfg_word[EBH_MAP_BIT] = map_bit;
        cfg_word[EBH_INHIBIT_BIT] = inhibit;
        cfg_word[EBH_REQ_BIT] = req_sync;
        cfg_word[EBH_ACK_BIT] = bus_grant_n;
    end

    // Address and data capture, in either order
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        wr_fire = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            wr_fire = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr == EBH_CFG2_OFFSET) ? EBH_RESP_OKAY : EBH_RESP_SLVERR;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // Read channel, one cycle answer
    always_comb begin
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = 32'h0000_0000;
            next_rresp = EBH_RESP_OKAY;
            if (s_axi_araddr == EBH_CFG2_OFFSET) begin
                next_rdata = cfg_word;
            end else if (s_axi_araddr == EBH_WBUF_OFFSET) begin
                next_rdata = {30'h0000_0000, fill_count};
            end else begin
                next_rresp = EBH_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= EBH_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= EBH_RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready || (!s_axi_arready && !s_axi_rvalid && !next_rvalid);
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ****************************************
    // Control bits
    // ****************************************
    logic cfg_wr, byte1_wr;

    // Software writes to byte 1 of the config word
    always_comb begin
        cfg_wr = wr_fire && (aw_addr == EBH_CFG2_OFFSET);
        byte1_wr = cfg_wr && w_strb[1];
        next_map_bit = map_bit;
        next_inhibit = inhibit;
        if (!aresetn) begin
            next_map_bit = pin_sync;
            next_inhibit = EBH_INHIBIT_RST;
        end else if (byte1_wr) begin
            next_map_bit = w_data[EBH_MAP_BIT];
            next_inhibit = w_data[EBH_INHIBIT_BIT];
        end
    end

    // Map bit follows the pin only while reset is held
    always_ff @(posedge aclk) begin
        map_bit <= next_map_bit;
        inhibit <= next_inhibit;
    end

    // ****************************************
    // Posted-write fill count
    // ****************************************
    logic [1:0] next_fill_count, next_fill_shown;
    logic [1:0] lag_pipe [EBH_FILL_LAG_CYC];

    // Saturating count, one per entry of any width
    always_comb begin
        next_fill_count = fill_count;
        if (wbuf_event.push && !wbuf_event.pop && fill_count != EBH_FILL_MAX) begin
            next_fill_count = fill_count + 2'h1;
        end else if (wbuf_event.pop && !wbuf_event.push && fill_count != EBH_FILL_RST) begin
            next_fill_count = fill_count - 2'h1;
        end
        next_fill_shown = lag_pipe[EBH_FILL_LAG_CYC - 1];
    end

    // Delay line feeding the status field
    generate
        for (genvar i = 0; i < EBH_FILL_LAG_CYC; i++) begin : g_lag
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    lag_pipe[i] <= EBH_FILL_RST;
                end else begin
                    lag_pipe[i] <= (i == 0) ? fill_count : lag_pipe[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_count <= EBH_FILL_RST;
            fill_shown <= EBH_FILL_RST;
        end else begin
            fill_count <= next_fill_count;
            fill_shown <= next_fill_shown;
        end
    end

    // ****************************************
    // Hold arbitration
    // ****************************************
    ebh_state_e state, next_state;
    logic next_grant_n, next_oe_n, next_not_ready;
    logic next_zone7, next_boot;

    // Grant, release and stall control
    always_comb begin
        next_state = state;
        unique case (state)
            EBH_IDLE: begin
                if (!req_sync && !inhibit) begin
                    next_state = EBH_GRANTED;
                end
            end
            EBH_GRANTED: begin
                if (inhibit || req_sync) begin
                    next_state = EBH_RELEASE;
                end
            end
            EBH_RELEASE: begin
                next_state = EBH_IDLE;
            end
            default: begin
                next_state = EBH_IDLE;
            end
        endcase
        if (!aresetn) begin
            next_state = req_sync ? EBH_IDLE : EBH_GRANTED;
        end
        next_grant_n = !(next_state == EBH_GRANTED);
        next_oe_n = (next_state == EBH_GRANTED);
        next_not_ready = ext_access && (next_state == EBH_GRANTED);
        next_zone7 = next_map_bit;
        next_boot = !next_map_bit;
    end

    always_ff @(posedge aclk) begin
        state <= next_state;
        bus_grant_n <= next_grant_n;
        ext_bus_oe_n <= next_oe_n;
        ext_not_ready <= next_not_ready;
        map_select <= next_map_bit;
        zone7_enable <= next_zone7;
        boot_rom_enable <= next_boot;
    end
endmodule
`default_nettype wire

/* verif/ebh_ctrl_props.sv */
/* Checker for ebh_ctrl port timing.
   Assumes bind from the bench top, one clock. */
`timescale 1ns/10ps
`default_nettype none
module ebh_ctrl_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic ext_bus_oe_n,
    input wire logic map_select,
    input wire logic zone7_enable,
    input wire logic boot_rom_enable,
    input wire logic ext_access,
    input wire logic ext_not_ready
);
    // ****************
    // Properties
    // ****************
    logic [3:0] w_hist;
    logic [3:0] next_w_hist;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // History of write data handshakes
    always_comb begin
        next_w_hist = {w_hist[2:0], s_axi_wvalid & s_axi_wready};
    end
    always_ff @(posedge aclk) begin
        w_hist <= next_w_hist;
    end
    map_pair_a: assert property (zone7_enable == map_select && boot_rom_enable == !map_select)
        else $error("zone and rom enables disagree with map bit");
    map_write_a: assert property ($changed(map_select) |-> w_hist != 4'h0)
        else $error("map bit moved without a write");
    float_grant_a: assert property (!bus_grant_n && $past(bus_grant_n) == 1'b0 |-> ext_bus_oe_n)
        else $error("bus driven while granted");
    grant_cause_a: assert property ($fell(bus_grant_n) |-> !$past(bus_request_n, 2) && !$past(bus_request_n, 3))
        else $error("grant without request");
    grant_release_a: assert property ($rose(bus_request_n) && !bus_grant_n |-> ##[1:6] bus_grant_n)
        else $error("grant kept after request left");
    not_ready_a: assert property (ext_not_ready |-> $past(ext_access) && ($past(bus_grant_n) == 1'b0 || !bus_grant_n))
        else $error("not ready without granted access");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
`default_nettype wire

/* verif/ebh_far_master.sv */
/* Outside bus master asking for the shared bus.
   Assumes the bench sets want after a clock edge. */
`timescale 1ns/10ps
`default_nettype none
module ebh_far_master (
    input wire logic aclk,
    input wire logic want,
    input wire logic bus_grant_n,
    output var logic bus_request_n,
    output var logic granted
);
    // ****************
    // Request pin
    // ****************
    initial bus_request_n = 1'b1;
    // Request held low for as long as wanted
    always @(posedge aclk) begin
        bus_request_n <= !want;
        granted <= !bus_grant_n;
    end
endmodule
`default_nettype wire

/* verif/ebh_ctrl_tb.sv */
/* Self-checking bench for ebh_ctrl over AXI4-Lite.
   Assumes ebh_pkg, the checker and the far master. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module ebh_ctrl_tb;
    import ebh_pkg::*;
    // ****************
    // Signals and parts
    // ****************
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, bus_request_n, map_select_pin = 1'b1, want = 1'b0;
    logic ext_access = 1'b0, granted, bus_grant_n, ext_bus_oe_n, map_select, zone7_enable;
    logic boot_rom_enable, ext_not_ready;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    ebh_wbuf_s wbuf_event = '0;
    int n_mismatch = 0, checked = 0;
    always #5 aclk = !aclk;
    ebh_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .bus_request_n, .map_select_pin, .bus_grant_n, .ext_bus_oe_n, .map_select,
        .zone7_enable, .boot_rom_enable, .wbuf_event, .ext_access, .ext_not_ready);
    ebh_far_master i_far (.aclk, .want, .bus_grant_n, .bus_request_n, .granted);
    // Verdict and end of run
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Wait bound
    task automatic guard(input int n);
        if (n > 200) begin
            n_mismatch++;
            final_report;
        end
    endtask
    // AXI write
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            guard(n);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // One edge apart so a next call never re-raises bready in this step
        @(posedge aclk);
    endtask
    // AXI read
    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            guard(n);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        // One edge apart so a next call never re-raises rready in this step
        @(posedge aclk);
    endtask
    // Config fields 11:6
    task automatic cfg(input logic [5:0] e);
        rd(EBH_CFG2_OFFSET);
        `CHK(d[11:6], e)
    endtask
    // Buffer event pulse
    task automatic ev(input logic pu, input logic po);
        wbuf_event <= '{push: pu, pop: po};
        @(posedge aclk);
        wbuf_event <= '0;
        @(posedge aclk);
    endtask
    // Bounded wait on grant level
    task automatic wgrant(input logic lvl);
        int n;
        n = 0;
        while (bus_grant_n !== lvl) begin
            @(posedge aclk);
            n++;
            guard(n);
        end
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        cfg(6'h34);
        `CHK({zone7_enable, boot_rom_enable}, 2'h2)
        map_select_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        cfg(6'h34);
        wr(EBH_CFG2_OFFSET, 32'h00000000, 4'h2);
        `CHK({r, map_select, zone7_enable, boot_rom_enable}, {EBH_RESP_OKAY, 3'h1})
        wr(EBH_CFG2_OFFSET, 32'h00000100, 4'h1);
        cfg(6'h30);
        $display("Test map done");
        repeat (4) ev(1'b1, 1'b0);
        rd(EBH_WBUF_OFFSET);
        `CHK(d[1:0], EBH_FILL_MAX)
        repeat (3) @(posedge aclk);
        cfg(6'h33);
        ev(1'b1, 1'b1);
        ev(1'b0, 1'b1);
        rd(EBH_WBUF_OFFSET);
        `CHK(d[1:0], 2'h2)
        repeat (3) ev(1'b0, 1'b1);
        rd(EBH_WBUF_OFFSET);
        `CHK(d[1:0], EBH_FILL_RST)
        $display("Test fill done");
        want <= 1'b1;
        wgrant(1'b0);
        @(posedge aclk);
        `CHK(ext_bus_oe_n, 1'b1)
        `CHK(granted, 1'b1)
        cfg(6'h00);
        ext_access <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK(ext_not_ready, 1'b1)
        ext_access <= 1'b0;
        wr(EBH_CFG2_OFFSET, 32'h00000200, 4'h2);
        wgrant(1'b1);
        @(posedge aclk);
        `CHK(ext_bus_oe_n, 1'b0)
        repeat (8) @(posedge aclk);
        cfg(6'h28);
        wr(EBH_CFG2_OFFSET, 32'h00000000, 4'h2);
        wgrant(1'b0);
        want <= 1'b0;
        wgrant(1'b1);
        $display("Test hold done");
        rd(12'h010);
        `CHK({r, d}, {EBH_RESP_SLVERR, 32'h00000000})
        wr(12'h010, 32'hFFFFFFFF, 4'hF);
        `CHK(r, EBH_RESP_SLVERR)
        cfg(6'h30);
        $display("Test unmapped done");
        wr(EBH_CFG2_OFFSET, 32'h00000200, 4'h2);
        aresetn <= 1'b0;
        want <= 1'b1;
        map_select_pin <= 1'b1;
        repeat (12) @(posedge aclk);
        `CHK({bus_grant_n, ext_bus_oe_n}, 2'h1)
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        cfg(6'h04);
        `CHK({zone7_enable, boot_rom_enable}, 2'h2)
        $display("Test reset done");
        final_report;
    end
endmodule
bind ebh_ctrl ebh_ctrl_props i_props (.aclk, .aresetn, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .bus_request_n,
    .bus_grant_n, .ext_bus_oe_n, .map_select, .zone7_enable, .boot_rom_enable, .ext_access,
    .ext_not_ready);
`default_nettype wire
